/* design/pmc_pkg.sv */
package pmc_pkg;

	// register byte offsets
	localparam logic [11:0] OFF_TASK_BEGIN  = 12'h000;
	localparam logic [11:0] OFF_TASK_HALT   = 12'h004;
	localparam logic [11:0] OFF_SUB_BEGIN   = 12'h080;
	localparam logic [11:0] OFF_SUB_HALT    = 12'h084;
	localparam logic [11:0] OFF_EV_STARTED  = 12'h100;
	localparam logic [11:0] OFF_EV_STOPPED  = 12'h104;
	localparam logic [11:0] OFF_EV_FULL     = 12'h108;
	localparam logic [11:0] OFF_PUB_STARTED = 12'h180;
	localparam logic [11:0] OFF_PUB_STOPPED = 12'h184;
	localparam logic [11:0] OFF_PUB_FULL    = 12'h188;
	localparam logic [11:0] OFF_IRQ_EN      = 12'h300;
	localparam logic [11:0] OFF_IRQ_SET     = 12'h304;
	localparam logic [11:0] OFF_IRQ_CLR     = 12'h308;
	localparam logic [11:0] OFF_ENABLE      = 12'h500;
	localparam logic [11:0] OFF_CLKCTRL     = 12'h504;
	localparam logic [11:0] OFF_MODE        = 12'h508;
	localparam logic [11:0] OFF_GAIN_L      = 12'h518;
	localparam logic [11:0] OFF_GAIN_R      = 12'h51c;
	localparam logic [11:0] OFF_RATIO       = 12'h520;
	localparam logic [11:0] OFF_PSEL_CLK    = 12'h540;
	localparam logic [11:0] OFF_PSEL_DIN    = 12'h544;
	localparam logic [11:0] OFF_PTR         = 12'h560;
	localparam logic [11:0] OFF_LEN         = 12'h564;

	// field positions
	localparam int MODE_MONO  = 0;  // operation: 1 = left only
	localparam int MODE_EDGE  = 1;  // 1 = left on rising edge
	localparam int PSEL_DISC  = 31; // 1 = signal not attached
	localparam int PSEL_PIN_W = 5;
	localparam int EV_STARTED = 0;
	localparam int EV_STOPPED = 1;
	localparam int EV_FULL    = 2;
	localparam int NUM_EV     = 3;
	localparam int LEN_W      = 16;
	localparam int DIV_W      = 8;

	// reset values and gain limits
	localparam logic [7:0]  GAIN_DEFAULT  = 8'h28;
	localparam logic [7:0]  GAIN_FLOOR    = 8'h00;
	localparam logic [7:0]  GAIN_CEIL     = 8'h50;
	localparam logic [31:0] CLKCTRL_RESET = 32'h0000000f;
	localparam logic [31:0] PSEL_RESET    = 32'h80000000;

	// bus and dma constants
	localparam logic [2:0]  HSIZE_WORD = 3'h2;
	localparam logic [3:0]  STRB_LO    = 4'h3;
	localparam logic [3:0]  STRB_HI    = 4'hc;
	localparam logic [31:0] ADDR_STEP  = 32'h00000002;

	// decimation and gain
	localparam logic [6:0] RATIO_64       = 7'h40;
	localparam logic [6:0] RATIO_80       = 7'h50;
	localparam logic [7:0] GAIN_BIAS      = 8'h08;
	localparam logic [7:0] GAIN_STEPS_6DB = 8'h0c;
	localparam logic [2:0] GAIN_UNITY_OCT = 3'h4;
	localparam int         MANT_FRAC      = 14;

	// one pcm sample with its strobe
	typedef struct packed {
		logic               valid;
		logic signed [15:0] sample;
	} pmc_samp_t;

	// one ram write: word address, lanes and data
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
	} pmc_dma_t;

	typedef enum logic [1:0] {RUN_IDLE, RUN_ACTIVE, RUN_DRAIN} pmc_run_t;

endpackage : pmc_pkg

/* design/pmc_decim.sv */
`timescale 1ns/1ps
module pmc_decim
	import pmc_pkg::*;
(
	input  logic      clk,
	input  logic      rst,
	input  logic      clear,
	input  logic      bit_valid,
	input  logic      bit_in,
	input  logic      ratio_80,
	output pmc_samp_t pcm
);
	typedef struct packed {
		logic [6:0] cnt;  // bits taken this period
		logic [6:0] ones; // ones taken this period
		pmc_samp_t  pcm;  // output sample
	} pmc_decim_t;

	pmc_decim_t        st_reg;
	pmc_decim_t        st_next;
	logic [6:0]        ratio;
	logic [6:0]        ones_inc;
	logic signed [8:0] diff;
	logic signed [17:0] scaled;

	// density count over one output period, mapped to signed pcm
	always_comb begin
		st_next = st_reg;
		st_next.pcm.valid = 1'b0;
		ratio = ratio_80 ? RATIO_80 : RATIO_64;
		ones_inc = st_reg.ones + {6'h00, bit_in};
		diff = $signed({1'b0, ones_inc, 1'b0}) - $signed({2'b00, ratio});
		scaled = {diff, 9'h000};
		if (clear) begin
			st_next = '0;
		end else if (bit_valid) begin
			st_next.ones = ones_inc;
			st_next.cnt = st_reg.cnt + 7'h01;
			// period end: one sample per ratio bits
			if (st_reg.cnt == ratio - 7'h01) begin
				st_next.cnt = 7'h00;
				st_next.ones = 7'h00;
				st_next.pcm.valid = 1'b1;
				if (scaled > 18'sd32767)
					st_next.pcm.sample = 16'h7fff;
				else if (scaled < -18'sd32768)
					st_next.pcm.sample = 16'h8000;
				else
					st_next.pcm.sample = scaled[15:0];
			end
		end
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign pcm = st_reg.pcm;

	a_out_period: assert property (
		@(posedge clk) disable iff (rst)
		(bit_valid && !clear && st_reg.cnt == ratio - 7'h01) |=> pcm.valid)
		else $error("decimator missed period end");

endmodule : pmc_decim

/* design/pmc_gain.sv */
`timescale 1ns/1ps
module pmc_gain
	import pmc_pkg::*;
(
	input  logic       clk,
	input  logic       rst,
	input  logic [7:0] gain,
	input  pmc_samp_t  din,
	output pmc_samp_t  dout
);
	pmc_samp_t          st_reg;  // registered output
	pmc_samp_t          st_next;
	logic [7:0]         g;       // clamped gain count
	logic [7:0]         e;       // biased count
	logic [2:0]         oct;     // whole 6 dB steps
	logic [3:0]         frac;    // half dB steps inside one 6 dB step
	logic [14:0]        mant;    // fraction gain, q14
	logic signed [32:0] prod;
	logic signed [39:0] base;
	logic signed [39:0] shifted;

	// gain = mant * 2^(oct-4), each count 0.5 dB
	always_comb begin
		st_next = din;
		g = (gain > GAIN_CEIL) ? GAIN_CEIL : gain;
		e = g + GAIN_BIAS;
		oct = 3'(e / GAIN_STEPS_6DB);
		frac = 4'(e % GAIN_STEPS_6DB);
		case (frac)
		4'h0: mant = 15'h4000;
		4'h1: mant = 15'h43cb;
		4'h2: mant = 15'h47cf;
		4'h3: mant = 15'h4c10;
		4'h4: mant = 15'h5092;
		4'h5: mant = 15'h5558;
		4'h6: mant = 15'h5a67;
		4'h7: mant = 15'h5fc2;
		4'h8: mant = 15'h656f;
		4'h9: mant = 15'h6b72;
		4'ha: mant = 15'h71cf;
		default: mant = 15'h788e;
		endcase
		prod = $signed({{17{din.sample[15]}}, din.sample})
			* $signed({18'h00000, mant});
		// signed operand, so the shift keeps the sign of a negative sample
		base = $signed({{7{prod[32]}}, prod}) >>> MANT_FRAC;
		if (oct >= GAIN_UNITY_OCT)
			shifted = base <<< (oct - GAIN_UNITY_OCT);
		else
			shifted = base >>> (GAIN_UNITY_OCT - oct);
		// saturate to 16 bits
		if (shifted > 40'sd32767)
			st_next.sample = 16'h7fff;
		else if (shifted < -40'sd32768)
			st_next.sample = 16'h8000;
		else
			st_next.sample = shifted[15:0];
	end

	// output register
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign dout = st_reg;

endmodule : pmc_gain

/* design/pmc_capture.sv */
// How it works
// - one data pin, left high, right low
// - two 16-bit samples per 64/80 bits
// - per-channel gain, 20 dB either side
// - separate gain counts, 0.5 dB each
// - samples stored little endian
// - length counts samples, two bytes each
// - stereo alternates left/right, mono left only
// - pointer latched at start, started event
// - full buffer: end event, continue, started only while acquiring
// - stop also ends with end event
// - disconnected select leaves signal unattached
// - pins routed only while block enabled
// - device drives the bit clock itself
// - edge field swaps left and right
// - stop after frame, then stopped event
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module pmc_capture
	import pmc_pkg::*;
(
	input  logic        clk,
	input  logic        rst,
	input  logic        hsel,
	input  logic [31:0] haddr,
	input  logic [1:0]  htrans,
	input  logic        hwrite,
	input  logic [2:0]  hsize,
	input  logic [31:0] hwdata,
	input  logic        hready,
	output logic        hreadyout,
	output logic [31:0] hrdata,
	output logic        hresp,
	output logic        dma_valid,
	input  logic        dma_ready,
	output pmc_dma_t    dma_req,
	input  logic [31:0] pin_in,
	input  logic [31:0] gpio_out,
	input  logic [31:0] gpio_oe_n,
	output logic [31:0] pin_out,
	output logic [31:0] pin_oe_n,
	output logic        bit_clock_out
);
	typedef struct packed {
		logic              aph_valid;   // data phase pending
		logic              aph_write;
		logic [11:0]       aph_addr;
		logic [31:0]       rdata;
		logic [31:0]       sub_begin;
		logic [31:0]       sub_halt;
		logic [31:0]       pub_started;
		logic [31:0]       pub_stopped;
		logic [31:0]       pub_full;
		logic [NUM_EV-1:0] ev;          // event flags
		logic [NUM_EV-1:0] irq_en;
		logic              enable;
		logic [31:0]       clkctrl;
		logic [1:0]        mode;
		logic [7:0]        gain_l;
		logic [7:0]        gain_r;
		logic              ratio;
		logic [31:0]       psel_clk;
		logic [31:0]       psel_din;
		logic [31:0]       ptr;         // next buffer pointer
		logic [LEN_W-1:0]  len;
		pmc_run_t          run;
		logic [31:0]       cur_addr;    // byte address of next sample
		logic [LEN_W-1:0]  count;       // samples in this buffer
		logic [DIV_W-1:0]  div;
		logic              clk_lvl;     // bit clock level
		logic              hold_fall;   // bit taken at falling edge
		logic              pend_l;
		logic              pend_r;
		logic [15:0]       samp_l;
		logic [15:0]       samp_r;
		logic              dma_valid;
		pmc_dma_t          dma;
		logic [31:0]       pin_out;
		logic [31:0]       pin_oe_n;
	} pmc_state_t;

	pmc_state_t            s;           // state register
	pmc_state_t            n;           // next state
	logic                  take;        // address phase accepted
	logic                  wr;          // write data phase now
	logic                  task_begin;
	logic                  task_halt;
	logic                  dma_done;
	logic                  clear;       // restart filters
	logic [NUM_EV-1:0]     set_ev;      // hardware event sets
	logic [NUM_EV-1:0]     irq_wbits;
	logic [15:0]           samp;
	logic                  running;
	logic                  div_hit;
	logic                  rise;
	logic                  fall;
	logic                  clk_conn;
	logic                  din_conn;
	logic [PSEL_PIN_W-1:0] clk_pin;
	logic [PSEL_PIN_W-1:0] din_pin;
	logic                  din;
	logic                  bit_l;
	logic                  bit_r;
	pmc_samp_t             d_l;
	pmc_samp_t             d_r;
	pmc_samp_t             g_l;
	pmc_samp_t             g_r;

	// pin routing only while enabled
	assign clk_conn = s.enable & ~s.psel_clk[PSEL_DISC];
	assign din_conn = s.enable & ~s.psel_din[PSEL_DISC];
	assign clk_pin  = s.psel_clk[PSEL_PIN_W-1:0];
	assign din_pin  = s.psel_din[PSEL_PIN_W-1:0];
	assign din      = din_conn ? pin_in[din_pin] : 1'b0;

	// bit clock edges while acquiring
	assign running = s.run == RUN_ACTIVE;
	assign div_hit = s.div == s.clkctrl[DIV_W-1:0];
	assign rise    = running & div_hit & ~s.clk_lvl;
	assign fall    = running & div_hit & s.clk_lvl;

	// high-phase bit is taken at the fall
	assign bit_l = s.mode[MODE_EDGE] ? din : s.hold_fall;
	assign bit_r = s.mode[MODE_EDGE] ? s.hold_fall : din;

	assign irq_wbits = hwdata[NUM_EV-1:0];
	assign dma_done  = s.dma_valid & dma_ready;

	// per-channel filter and volume stage
	pmc_decim u_dec_l (
		.clk       (clk),
		.rst       (rst),
		.clear     (clear),
		.bit_valid (rise),
		.bit_in    (bit_l),
		.ratio_80  (s.ratio),
		.pcm       (d_l)
	);
	pmc_decim u_dec_r (
		.clk       (clk),
		.rst       (rst),
		.clear     (clear),
		.bit_valid (rise),
		.bit_in    (bit_r),
		.ratio_80  (s.ratio),
		.pcm       (d_r)
	);
	pmc_gain u_gain_l (
		.clk  (clk),
		.rst  (rst),
		.gain (s.gain_l),
		.din  (d_l),
		.dout (g_l)
	);
	pmc_gain u_gain_r (
		.clk  (clk),
		.rst  (rst),
		.gain (s.gain_r),
		.din  (d_r),
		.dout (g_r)
	);

	// whole next-state logic
	always_comb begin
		n = s;
		set_ev = '0;
		clear = 1'b0;
		samp = s.pend_l ? s.samp_l : s.samp_r;
		wr = s.aph_valid & s.aph_write;
		task_begin = wr && s.aph_addr == OFF_TASK_BEGIN && hwdata[0];
		task_halt = wr && s.aph_addr == OFF_TASK_HALT && hwdata[0];
		take = hsel & htrans[1] & hready & (hsize == HSIZE_WORD);

		// data phase writes
		if (wr) begin
			case (s.aph_addr)
			OFF_SUB_BEGIN:   n.sub_begin = hwdata;
			OFF_SUB_HALT:    n.sub_halt = hwdata;
			OFF_PUB_STARTED: n.pub_started = hwdata;
			OFF_PUB_STOPPED: n.pub_stopped = hwdata;
			OFF_PUB_FULL:    n.pub_full = hwdata;
			OFF_EV_STARTED:  n.ev[EV_STARTED] = hwdata[0];
			OFF_EV_STOPPED:  n.ev[EV_STOPPED] = hwdata[0];
			OFF_EV_FULL:     n.ev[EV_FULL] = hwdata[0];
			OFF_IRQ_EN:      n.irq_en = irq_wbits;
			OFF_IRQ_SET:     n.irq_en = s.irq_en | irq_wbits;
			OFF_IRQ_CLR:     n.irq_en = s.irq_en & ~irq_wbits;
			OFF_ENABLE:      n.enable = hwdata[0];
			OFF_CLKCTRL:     n.clkctrl = hwdata;
			OFF_MODE:        n.mode = hwdata[1:0];
			OFF_GAIN_L:      n.gain_l = hwdata[7:0];
			OFF_GAIN_R:      n.gain_r = hwdata[7:0];
			OFF_RATIO:       n.ratio = hwdata[0];
			OFF_PSEL_CLK:    n.psel_clk = hwdata;
			OFF_PSEL_DIN:    n.psel_din = hwdata;
			OFF_PTR:         n.ptr = hwdata;
			OFF_LEN:         n.len = hwdata[LEN_W-1:0];
			default: ;
			endcase
		end

		// address phase: capture and prepare read data
		n.aph_valid = take;
		n.aph_write = hwrite;
		n.aph_addr = {haddr[11:2], 2'b00};
		if (take && !hwrite) begin
			case ({haddr[11:2], 2'b00})
			OFF_SUB_BEGIN:   n.rdata = s.sub_begin;
			OFF_SUB_HALT:    n.rdata = s.sub_halt;
			OFF_PUB_STARTED: n.rdata = s.pub_started;
			OFF_PUB_STOPPED: n.rdata = s.pub_stopped;
			OFF_PUB_FULL:    n.rdata = s.pub_full;
			OFF_EV_STARTED:  n.rdata = 32'(s.ev[EV_STARTED]);
			OFF_EV_STOPPED:  n.rdata = 32'(s.ev[EV_STOPPED]);
			OFF_EV_FULL:     n.rdata = 32'(s.ev[EV_FULL]);
			OFF_IRQ_EN,
			OFF_IRQ_SET,
			OFF_IRQ_CLR:     n.rdata = 32'(s.irq_en);
			OFF_ENABLE:      n.rdata = 32'(s.enable);
			OFF_CLKCTRL:     n.rdata = s.clkctrl;
			OFF_MODE:        n.rdata = 32'(s.mode);
			OFF_GAIN_L:      n.rdata = 32'(s.gain_l);
			OFF_GAIN_R:      n.rdata = 32'(s.gain_r);
			OFF_RATIO:       n.rdata = 32'(s.ratio);
			OFF_PSEL_CLK:    n.rdata = s.psel_clk;
			OFF_PSEL_DIN:    n.rdata = s.psel_din;
			OFF_PTR:         n.rdata = s.ptr;
			OFF_LEN:         n.rdata = 32'(s.len);
			default:         n.rdata = 32'h00000000;
			endcase
		end

		// bit clock divider, stopped outside acquisition
		if (running) begin
			if (div_hit) begin
				n.div = '0;
				n.clk_lvl = ~s.clk_lvl;
			end else begin
				n.div = s.div + 8'h01;
			end
			if (fall)
				n.hold_fall = din;
		end else begin
			n.div = '0;
			n.clk_lvl = 1'b0;
		end

		// ram write finished: step two bytes per sample
		if (dma_done) begin
			n.dma_valid = 1'b0;
			n.count = s.count + 16'h0001;
			n.cur_addr = s.cur_addr + ADDR_STEP;
			// buffer full: end, then next buffer
			if (s.count + 16'h0001 == s.len) begin
				set_ev[EV_FULL] = 1'b1;
				n.count = '0;
				n.cur_addr = s.ptr;
				if (running)
					set_ev[EV_STARTED] = 1'b1;
			end
		end

		// issue next sample, left before right
		if (!s.dma_valid && (s.pend_l || s.pend_r)) begin
			n.dma_valid = 1'b1;
			n.dma.addr = {s.cur_addr[31:2], 2'b00};
			// little endian halfword lanes
			if (s.cur_addr[1]) begin
				n.dma.wdata = {samp, 16'h0000};
				n.dma.wstrb = STRB_HI;
			end else begin
				n.dma.wdata = {16'h0000, samp};
				n.dma.wstrb = STRB_LO;
			end
			if (s.pend_l)
				n.pend_l = 1'b0;
			else
				n.pend_r = 1'b0;
		end

		// new sample pair; right dropped in mono
		if (running && g_l.valid) begin
			n.pend_l = 1'b1;
			n.samp_l = g_l.sample;
			if (!s.mode[MODE_MONO]) begin
				n.pend_r = 1'b1;
				n.samp_r = g_r.sample;
			end
		end

		// acquisition control
		case (s.run)
		RUN_IDLE: begin
			// latch pointer at start
			if (task_begin && s.enable) begin
				n.run = RUN_ACTIVE;
				n.cur_addr = s.ptr;
				n.count = '0;
				n.pend_l = 1'b0;
				n.pend_r = 1'b0;
				set_ev[EV_STARTED] = 1'b1;
				clear = 1'b1;
			end
		end
		RUN_ACTIVE: begin
			// no new frames after stop or disable
			if (task_halt || !s.enable)
				n.run = RUN_DRAIN;
		end
		RUN_DRAIN: begin
			// last write done: end and stopped events in the same cycle
			if (!s.pend_l && !s.pend_r && !s.dma_valid) begin
				n.run = RUN_IDLE;
				set_ev[EV_FULL] = 1'b1;
				set_ev[EV_STOPPED] = 1'b1;
			end
		end
		default: n.run = RUN_IDLE;
		endcase

		// hardware set wins over software clear
		n.ev = n.ev | set_ev;

		// pin drivers: gpio unless routed
		n.pin_out = gpio_out;
		n.pin_oe_n = gpio_oe_n;
		if (din_conn)
			n.pin_oe_n[din_pin] = 1'b1;
		if (clk_conn) begin
			n.pin_out[clk_pin] = n.clk_lvl;
			n.pin_oe_n[clk_pin] = 1'b0;
		end
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
			s.gain_l <= GAIN_DEFAULT;
			s.gain_r <= GAIN_DEFAULT;
			s.clkctrl <= CLKCTRL_RESET;
			s.psel_clk <= PSEL_RESET;
			s.psel_din <= PSEL_RESET;
			s.run <= RUN_IDLE;
			s.pin_oe_n <= '1;
		end else begin
			s <= n;
		end
	end

	// outputs
	assign hreadyout     = 1'b1;
	assign hresp         = 1'b0;
	assign hrdata        = s.rdata;
	assign dma_valid     = s.dma_valid;
	assign dma_req       = s.dma;
	assign pin_out       = s.pin_out;
	assign pin_oe_n      = s.pin_oe_n;
	assign bit_clock_out = s.clk_lvl;

	a_start_latch: assert property (
		@(posedge clk) disable iff (rst)
		(s.run == RUN_IDLE && task_begin && s.enable) |=>
		(running && s.cur_addr == $past(s.ptr) && s.ev[EV_STARTED]))
		else $error("start did not latch pointer");

	a_full_restart: assert property (
		@(posedge clk) disable iff (rst)
		(dma_done && s.count + 16'h0001 == s.len) |=>
		(s.ev[EV_FULL] && s.count == 16'h0000 &&
		 s.cur_addr == $past(s.ptr)))
		else $error("full buffer did not restart");

	a_addr_step: assert property (
		@(posedge clk) disable iff (rst)
		(dma_done && s.count + 16'h0001 != s.len) |=>
		(s.cur_addr == $past(s.cur_addr) + ADDR_STEP))
		else $error("sample address did not step by two");

	a_lane_order: assert property (
		@(posedge clk) disable iff (rst)
		$rose(s.dma_valid) |->
		(s.dma.wstrb == (s.cur_addr[1] ? STRB_HI : STRB_LO)))
		else $error("wrong byte lanes for sample");

	a_mono_only: assert property (
		@(posedge clk) disable iff (rst)
		(running && g_l.valid && s.mode[MODE_MONO] && !s.pend_r)
		|=> !s.pend_r)
		else $error("right sample queued in mono");

	a_stop_events: assert property (
		@(posedge clk) disable iff (rst)
		(s.run == RUN_DRAIN && !s.pend_l && !s.pend_r && !s.dma_valid)
		|=> (s.run == RUN_IDLE && s.ev[EV_STOPPED] && s.ev[EV_FULL]))
		else $error("stop did not end with events");

	a_gpio_revert: assert property (
		@(posedge clk) disable iff (rst)
		!s.enable |=> (s.pin_out == $past(gpio_out) &&
		s.pin_oe_n == $past(gpio_oe_n)))
		else $error("pins not returned to gpio");

	a_disc_pins: assert property (
		@(posedge clk) disable iff (rst)
		(s.psel_clk[PSEL_DISC] && s.psel_din[PSEL_DISC]) |=>
		(s.pin_oe_n == $past(gpio_oe_n)))
		else $error("disconnected signal reached a pin");

	a_clock_quiet: assert property (
		@(posedge clk) disable iff (rst)
		(s.run != RUN_ACTIVE) |=> !s.clk_lvl)
		else $error("bit clock toggled while idle");

	a_irq_set: assert property (
		@(posedge clk) disable iff (rst)
		(wr && s.aph_addr == OFF_IRQ_SET) |=>
		(s.irq_en == ($past(s.irq_en) | $past(irq_wbits))))
		else $error("enable set bits not applied");

endmodule : pmc_capture

/* bench/pmc_mic_model.sv */
`timescale 1ns/1ps
// two microphones sharing one data line; neither line is ever released
module pmc_mic_model (
	input  wire logic bit_clock_out,
	input  wire logic left_level,
	input  wire logic right_level,
	output logic      mic_data
);
	// left talks while the clock is high, right while it is low
	// constant levels: no settling transient, nothing to discard
	always @(bit_clock_out) begin
		mic_data = bit_clock_out ? left_level : right_level;
	end
	initial mic_data = 1'b0;
endmodule : pmc_mic_model

/* bench/test_pmc_capture.sv */
`timescale 1ns/1ps
module test_pmc_capture;
	import pmc_pkg::*;
	logic        clk, rst, hsel, hwrite, hreadyout, hresp, mic_data;
	logic        dma_valid, dma_ready, bit_clock_out, rnd_rdy, st_chk;
	logic [31:0] haddr, hwdata, hrdata, pin_in, gpio_out, gpio_oe_n;
	logic [31:0] pin_out, pin_oe_n;
	logic [1:0]  htrans;
	pmc_dma_t    dma_req;
	int          error_cnt, cmp_count, cyc, wcnt, lt, seed, period;
	logic [7:0]  mem[logic [31:0]]; // ram image, one byte per address
	logic [11:0] rv_off[7] = '{OFF_GAIN_L, OFF_GAIN_R, OFF_CLKCTRL,
		OFF_PSEL_CLK, OFF_PSEL_DIN, OFF_ENABLE, 12'hffc};
	logic [31:0] rv_val[7] = '{{24'h0, GAIN_DEFAULT}, {24'h0, GAIN_DEFAULT},
		CLKCTRL_RESET, PSEL_RESET, PSEL_RESET, 32'h0, 32'h0};
	// data pin 7 carries the microphones, other pins echo gpio
	assign pin_in = (gpio_out & ~32'h80) | {24'h0, mic_data, 7'h0};
	pmc_capture dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .dma_valid(dma_valid),
		.dma_ready(dma_ready), .dma_req(dma_req), .pin_in(pin_in),
		.gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .bit_clock_out(bit_clock_out));
	pmc_mic_model mic (.bit_clock_out(bit_clock_out), .left_level(1'b1),
		.right_level(1'b0), .mic_data(mic_data));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic check(input string n, input logic [31:0] s,
		input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask : check
	task stop_test;
		if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	// one single ahb transfer, waiting on hready in both phases
	task ahb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : ahb
	// full-scale value of a channel whose microphone holds one level
	function automatic logic [15:0] exp_s(input logic hi);
		return hi ? 16'h7fff : 16'h8000;
	endfunction : exp_s
	// full scale, or 20 dB below it when the gain sits at its floor
	function automatic logic [15:0] exp_v(input logic hi, input logic at);
		return at ? 16'd3277 : exp_s(hi);
	endfunction : exp_v
	// attenuated samples get a quarter dB of slack either side
	function automatic logic [15:0] seen_v(input logic [15:0] v,
		input logic at);
		return (at && v > 16'd3180 && v < 16'd3380) ? 16'd3277 : v;
	endfunction : seen_v
	task run_cfg(input int c);
		logic [31:0] p1, r;
		logic        sw, mo;
		mo = (c == 2);
		sw = (c == 1);
		p1 = 32'h20000000 + 32'(c * 2);
		mem.delete();
		ahb(1, OFF_MODE, {30'h0, sw, mo}, r);
		ahb(1, OFF_RATIO, {31'h0, sw}, r);
		// gains stay within floor and ceiling; mono uses the floor
		ahb(1, OFF_GAIN_L, mo ? {24'h0, GAIN_FLOOR}
			: 32'h28 + 32'($unsigned($random(seed)) % 41), r);
		ahb(1, OFF_GAIN_R, 32'h28 + 32'($unsigned($random(seed)) % 41), r);
		ahb(1, OFF_PTR, p1, r);
		ahb(1, OFF_LEN, 32'h6, r);
		ahb(1, OFF_EV_STOPPED, 32'h0, r);
		period = (sw ? 80 : 64) * 4;
		st_chk = !mo;
		rnd_rdy = mo;
		lt = 0;
		wcnt = 0;
		ahb(1, OFF_TASK_BEGIN, 32'h1, r);
		ahb(0, OFF_EV_STARTED, 32'h0, r);
		check("started", r, 32'h1);
		check("clock pin", {31'h0, pin_out[3]}, {31'h0, bit_clock_out});
		ahb(1, OFF_EV_STARTED, 32'h0, r);
		ahb(1, OFF_PTR, p1 + 32'h80, r);
		for (int i = 0; i < 5000 && wcnt < 7; i++) @(posedge clk);
		ahb(0, OFF_EV_FULL, 32'h0, r);
		check("full", r, 32'h1);
		ahb(0, OFF_EV_STARTED, 32'h0, r);
		check("restarted", r, 32'h1);
		ahb(1, OFF_EV_FULL, 32'h0, r);
		ahb(1, OFF_TASK_HALT, 32'h1, r);
		r = 0;
		for (int i = 0; i < 200 && r !== 32'h1; i++)
			ahb(0, OFF_EV_STOPPED, 32'h0, r);
		check("stopped", r, 32'h1);
		ahb(0, OFF_EV_FULL, 32'h0, r);
		check("stop full", r, 32'h1);
		check("idle clock", {31'h0, bit_clock_out}, 32'h0);
		for (int k = 0; k < 6; k++)
			check("sample",
				{16'h0, seen_v({mem[p1 + 2 * k + 1], mem[p1 + 2 * k]}, mo)},
				{16'h0, exp_v((mo || k % 2 == 0) ^ sw, mo)});
		check("past end", {31'h0, mem.exists(p1 + 12)}, 32'h0);
		check("next buf",
			{16'h0, seen_v({mem[p1 + 32'h81], mem[p1 + 32'h80]}, mo)},
			{16'h0, exp_v(!sw, mo)});
	endtask : run_cfg
	// ram side: takes each write, keeps the bytes and times the pairs
	always @(posedge clk) begin
		if (rnd_rdy) dma_ready <= ($random(seed) % 4) != 0;
		if (dma_valid === 1'b1 && dma_ready === 1'b1) begin
			for (int i = 0; i < 4; i++)
				if (dma_req.wstrb[i]) mem[dma_req.addr + i] = dma_req.wdata[8*i+:8];
			if (st_chk && wcnt % 2 == 0) begin
				if (lt != 0) check("pair gap", cyc - lt, period);
				lt = cyc;
			end
			wcnt++;
		end
	end
	// hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			error_cnt++;
			stop_test();
		end
	end
	initial begin
		logic [31:0] r;
		seed = 32074;
		{rst, hsel, hwrite, haddr, hwdata, htrans} = '1;
		{hsel, hwrite, haddr, hwdata, htrans, rnd_rdy, st_chk} = '0;
		{dma_ready, gpio_out, gpio_oe_n} = {1'b1, 32'h0, 32'hffffffff};
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		foreach (rv_off[i]) begin
			ahb(0, rv_off[i], 32'h0, r);
			check("reset value", r, rv_val[i]);
		end
		ahb(1, OFF_IRQ_SET, 32'h5, r);
		ahb(1, OFF_IRQ_CLR, 32'h1, r);
		ahb(1, OFF_IRQ_SET, 32'h0, r);
		ahb(0, OFF_IRQ_CLR, 32'h0, r);
		check("irq enable", r, 32'h4);
		check("bus okay", {31'h0, hresp}, 32'h0);
		gpio_out <= $random(seed);
		gpio_oe_n <= $random(seed);
		ahb(1, OFF_PSEL_CLK, 32'h3, r);
		// clock and data on distinct pins, neither shared
		ahb(1, OFF_PSEL_DIN, 32'h7, r);
		check("gpio oe", pin_oe_n, gpio_oe_n);
		check("gpio out", pin_out, gpio_out);
		ahb(1, OFF_CLKCTRL, 32'h1, r);
		ahb(1, OFF_ENABLE, 32'h1, r);
		repeat (2) @(posedge clk);
		check("pin oe", {30'h0, pin_oe_n[7], pin_oe_n[3]}, 32'h2);
		for (int c = 0; c < 3; c++) run_cfg(c);
		ahb(1, OFF_ENABLE, 32'h0, r);
		repeat (2) @(posedge clk);
		check("gpio back", pin_oe_n, gpio_oe_n);
		check("gpio out back", pin_out, gpio_out);
		stop_test();
	end
endmodule : test_pmc_capture
